// ==== src/cmpis_map.svh ====
// Register offsets, field positions, reset values and sense codes for the comparator sense block.
// Assumes a 32-bit classic Wishbone slave with byte addresses and word-aligned registers.
`ifndef CMPIS_MAP_SVH
`define CMPIS_MAP_SVH

`define CMPIS_OFF_CONTROL    8'h24
`define CMPIS_OFF_STATUS     8'h00
`define CMPIS_OFF_INT_CLEAR  8'h04
`define CMPIS_OFF_INT_ENABLE 8'h08
`define CMPIS_OFF_OUTPUT     8'h0C

`define CMPIS_BIT_INVERT     1
`define CMPIS_BIT_SENSE_LO   2
`define CMPIS_BIT_SENSE_HI   3
`define CMPIS_BIT_LEVEL      4
`define CMPIS_BIT_SRC_LO     9
`define CMPIS_BIT_SRC_HI     10

`define CMPIS_CONTROL_MASK   32'h0000061E
`define CMPIS_CONTROL_RESET  32'h00000000

`define CMPIS_SENSE_LEVEL    2'h0
`define CMPIS_SENSE_FALL     2'h1
`define CMPIS_SENSE_RISE     2'h2
`define CMPIS_SENSE_BOTH     2'h3

`define CMPIS_BIT_EVT_SENSE  0
`define CMPIS_BIT_EVT_CHANGE 1
`define CMPIS_EVT_WIDTH      2

`endif

// ==== src/cmpis_pkg.sv ====
// Types shared by the comparator sense block.
// Assumes cmpis_map.svh supplies the numeric constants.
package cmpis_pkg;

    typedef enum logic [1:0] {
        CMPIS_LEVEL,
        CMPIS_FALL,
        CMPIS_RISE,
        CMPIS_BOTH
    } cmpis_sense_type;

    typedef enum logic [1:0] {
        CMPIS_IDLE,
        CMPIS_ACK
    } cmpis_bus_type;

    function automatic cmpis_sense_type cmpis_decode_sense(input logic [1:0] code);
        case (code)
            2'h0:    cmpis_decode_sense = CMPIS_LEVEL;
            2'h1:    cmpis_decode_sense = CMPIS_FALL;
            2'h2:    cmpis_decode_sense = CMPIS_RISE;
            default: cmpis_decode_sense = CMPIS_BOTH;
        endcase
    endfunction : cmpis_decode_sense

endpackage : cmpis_pkg

// ==== src/cmpis_sense.sv ====
// Edge and level sense stage: turns the conditioned output into a sense condition.
// Assumes a synchronised input; the previous value is held here for edge detection.
`timescale 1ns/10ps
module cmpis_sense
    import cmpis_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Control
    input  wire cmpis_sense_type mode_i,
    input  wire logic            level_sel_i,
    // Signal
    input  wire logic            value_i,
    output logic                 hit_o,
    output logic                 change_o
);
    logic prev_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= value_i;
        end
    end

    assign rise     = value_i & ~prev_q;
    assign fall     = ~value_i & prev_q;
    assign change_o = rise | fall;

    always_comb begin
        case (mode_i)
            CMPIS_LEVEL: hit_o = level_sel_i ? ~value_i : value_i; // RULE2 RULE6
            CMPIS_FALL:  hit_o = fall;                              // RULE1
            CMPIS_RISE:  hit_o = rise;                              // RULE1
            CMPIS_BOTH:  hit_o = rise | fall;                       // RULE1
            default:     hit_o = 1'b0;
        endcase
    end

endmodule : cmpis_sense

// ==== src/cmpis_sync.sv ====
// Three-stage synchroniser for the asynchronous comparator output.
// Assumes one clock; the output changes only when stages two and three agree.
`timescale 1ns/10ps
module cmpis_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Signal
    input  wire logic async_i,
    output logic      level_o
);
    logic [2:0] stage_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], async_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            level_o <= stage_q[2];
        end
    end

endmodule : cmpis_sync

// ==== src/cmpis_top.sv ====
// Comparator output conditioning and interrupt sense, with a classic Wishbone register slave.
// Assumes the comparator output is asynchronous and software keeps reserved bits on writes.
//
// Operation
// RULE1: The two-bit sense field picks level, falling edge, rising edge or either edge as interrupt condition.
// RULE2: In level mode with the level select clear, an interrupt is requested while the output is high.
// RULE3: With the invert bit set, the comparator output is inverted before any sensing.
// RULE4: With the invert bit clear, the comparator output passes to sensing unchanged.
// RULE5: Software keeps reserved control bits by writing back what it read.
// RULE6: In level mode with the level select set, an interrupt is requested while the output is low.
`timescale 1ns/10ps
`include "cmpis_map.svh"
module cmpis_top
    import cmpis_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             err_o,
    // Comparator
    input  wire logic        cmp_out_i,
    output logic [1:0]       positive_source_select_o,
    output logic             cmp_value_o,
    // Interrupt
    output logic             irq_o
);
    logic [31:0]                   comparator_control_q;
    logic [`CMPIS_EVT_WIDTH-1:0]   int_status_q;
    logic [`CMPIS_EVT_WIDTH-1:0]   int_enable_q;
    logic [`CMPIS_EVT_WIDTH-1:0]   events;
    logic [`CMPIS_EVT_WIDTH-1:0]   clear_mask;
    logic                          cmp_sync;
    logic                          cmp_cond;
    logic                          sense_hit;
    logic                          sense_change;
    logic                          req;
    logic                          wr_take;
    logic                          addr_ok;
    logic                          hit_control;
    logic                          hit_status;
    logic                          hit_clear;
    logic                          hit_enable;
    logic                          hit_output;
    cmpis_bus_type                 bus_q;
    cmpis_sense_type               mode;

    function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        apply_sel = r;
    endfunction : apply_sel

    // Registers are word aligned, so the two low address bits never take part in a match.
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
        reg_hit = (adr[7:2] == off[7:2]);
    endfunction : reg_hit

    cmpis_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cmp_out_i),
        .level_o (cmp_sync)
    );

    // Invert applies ahead of every consumer, including the status view.
    assign cmp_cond = comparator_control_q[`CMPIS_BIT_INVERT] ? ~cmp_sync : cmp_sync; // RULE3 RULE4
    assign mode     = cmpis_decode_sense(comparator_control_q[`CMPIS_BIT_SENSE_HI:`CMPIS_BIT_SENSE_LO]);

    cmpis_sense u_sense (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .mode_i      (mode),
        .level_sel_i (comparator_control_q[`CMPIS_BIT_LEVEL]),
        .value_i     (cmp_cond),
        .hit_o       (sense_hit),
        .change_o    (sense_change)
    );

    assign positive_source_select_o = comparator_control_q[`CMPIS_BIT_SRC_HI:`CMPIS_BIT_SRC_LO];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_value_o <= 1'b0;
        end else begin
            cmp_value_o <= cmp_cond;
        end
    end

    // Bus: one wait state, ack answers on the second edge of a request.
    assign req         = cyc_i & stb_i & (bus_q == CMPIS_IDLE);
    assign hit_control = reg_hit(adr_i, `CMPIS_OFF_CONTROL);
    assign hit_status  = reg_hit(adr_i, `CMPIS_OFF_STATUS);
    assign hit_clear   = reg_hit(adr_i, `CMPIS_OFF_INT_CLEAR);
    assign hit_enable  = reg_hit(adr_i, `CMPIS_OFF_INT_ENABLE);
    assign hit_output  = reg_hit(adr_i, `CMPIS_OFF_OUTPUT);
    assign addr_ok     = hit_control | hit_status | hit_clear | hit_enable | hit_output;
    // Writes land at the edge where the master sees ack, so a request withdrawn early never writes.
    assign wr_take     = cyc_i & stb_i & we_i & ack_o & addr_ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= CMPIS_IDLE;
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            case (bus_q)
                CMPIS_IDLE: begin
                    ack_o <= req & addr_ok;
                    err_o <= req & ~addr_ok;
                    if (req) begin
                        bus_q <= CMPIS_ACK;
                    end
                end
                CMPIS_ACK: begin
                    ack_o <= 1'b0;
                    err_o <= 1'b0;
                    bus_q <= CMPIS_IDLE;
                end
                default: bus_q <= CMPIS_IDLE;
            endcase
        end
    end

    // Reserved control bits stay zero whatever software writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comparator_control_q <= `CMPIS_CONTROL_RESET;
        end else if (wr_take && hit_control) begin
            comparator_control_q <= apply_sel(comparator_control_q, dat_i, sel_i) & `CMPIS_CONTROL_MASK; // RULE5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_enable_q <= '0;
        end else if (wr_take && hit_enable && sel_i[0]) begin
            int_enable_q <= dat_i[`CMPIS_EVT_WIDTH-1:0];
        end
    end

    assign events[`CMPIS_BIT_EVT_SENSE]  = sense_hit;    // RULE1
    assign events[`CMPIS_BIT_EVT_CHANGE] = sense_change;
    assign clear_mask = (wr_take && hit_clear && sel_i[0]) ?
                        dat_i[`CMPIS_EVT_WIDTH-1:0] : '0;

    // A level condition that persists re-sets its bit right after a clear; set wins over clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_status_q <= '0;
        end else begin
            int_status_q <= (int_status_q & ~clear_mask) | events;
        end
    end

    assign irq_o = |(int_status_q & int_enable_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (req && !we_i) begin
            case (1'b1)
                hit_control:                dat_o <= comparator_control_q;
                hit_status:                 dat_o <= {30'h00000000, int_status_q};
                hit_enable:                 dat_o <= {30'h00000000, int_enable_q};
                hit_output:                 dat_o <= {30'h00000000, cmp_value_o, 1'b0};
                default:                    dat_o <= 32'h00000000;
            endcase
        end
    end

    a_invert_path: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        comparator_control_q[`CMPIS_BIT_INVERT] |-> (cmp_cond == ~cmp_sync))
        else $error("inverted output not applied");

    a_pass_path: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        !comparator_control_q[`CMPIS_BIT_INVERT] |-> (cmp_cond == cmp_sync))
        else $error("output not passed unchanged");

    a_level_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (mode == CMPIS_LEVEL && !comparator_control_q[`CMPIS_BIT_LEVEL] && cmp_cond && !clear_mask[0])
        |=> int_status_q[`CMPIS_BIT_EVT_SENSE])
        else $error("level high did not set status");

    a_level_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        (mode == CMPIS_LEVEL && comparator_control_q[`CMPIS_BIT_LEVEL] && !cmp_cond)
        |=> int_status_q[`CMPIS_BIT_EVT_SENSE])
        else $error("level low did not set status");

    a_rise_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode == CMPIS_RISE && $rose(cmp_cond) && $stable(comparator_control_q)) |-> sense_hit)
        else $error("rising edge missed");

    a_fall_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode == CMPIS_FALL && $fell(cmp_cond) && $stable(comparator_control_q)) |-> sense_hit)
        else $error("falling edge missed");

    a_no_false_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode != CMPIS_LEVEL && $stable(cmp_cond) && $stable(comparator_control_q)) |-> !sense_hit)
        else $error("edge sensed without change");

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        ack_o |-> ((comparator_control_q & ~`CMPIS_CONTROL_MASK) == 32'h00000000))
        else $error("reserved control bits set");

    a_both_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode == CMPIS_BOTH && $changed(cmp_cond)) |-> sense_hit)
        else $error("either edge missed");

    a_fall_only: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode == CMPIS_FALL && $rose(cmp_cond)) |-> !sense_hit)
        else $error("rising edge sensed in falling mode");

    a_rise_only: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (mode == CMPIS_RISE && $fell(cmp_cond)) |-> !sense_hit)
        else $error("falling edge sensed in rising mode");

    a_level_quiet_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (mode == CMPIS_LEVEL && !comparator_control_q[`CMPIS_BIT_LEVEL] && !cmp_cond) |-> !sense_hit)
        else $error("low output sensed with level select clear");

    a_level_quiet_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        (mode == CMPIS_LEVEL && comparator_control_q[`CMPIS_BIT_LEVEL] && cmp_cond) |-> !sense_hit)
        else $error("high output sensed with level select set");

    a_change_event: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(cmp_cond) |-> sense_change)
        else $error("output change not flagged");

    a_value_view: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3 RULE4
        1'b1 |=> (cmp_value_o == $past(cmp_cond)))
        else $error("output view does not follow conditioned output");

    a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (int_status_q[`CMPIS_BIT_EVT_SENSE] && !clear_mask[`CMPIS_BIT_EVT_SENSE])
        |=> int_status_q[`CMPIS_BIT_EVT_SENSE])
        else $error("sense status lost without a clear");

    a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
        (int_status_q[`CMPIS_BIT_EVT_SENSE] && clear_mask[`CMPIS_BIT_EVT_SENSE] && !sense_hit)
        |=> !int_status_q[`CMPIS_BIT_EVT_SENSE])
        else $error("sense status not cleared");

    a_irq_needs_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        irq_o |-> (int_status_q != '0))
        else $error("interrupt without a status bit");

    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && addr_ok) |=> ack_o)
        else $error("mapped request not acknowledged");

    a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !addr_ok) |=> (err_o && !ack_o))
        else $error("unmapped request not refused");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");

    a_err_single: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("err longer than one cycle");

    a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ack_o && err_o))
        else $error("ack and err together");

    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");

    a_control_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_take && hit_control) |=> $stable(comparator_control_q))
        else $error("control changed without a write");

    a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_take && hit_enable && sel_i[0]) |=> $stable(int_enable_q))
        else $error("enable changed without a write");

    a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> ($stable(comparator_control_q) && $stable(int_enable_q)))
        else $error("refused request wrote a register");

    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && hit_status) |=> (dat_o[1:0] == $past(int_status_q)))
        else $error("status read returned wrong value");

    a_control_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && hit_control) |=> (dat_o == $past(comparator_control_q)))
        else $error("control read returned wrong value");

    a_clear_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && hit_clear) |=> (dat_o == 32'h00000000))
        else $error("clear register read not zero");

endmodule : cmpis_top

// ==== testbench/cmpis_cmp_model.sv ====
// Behavioural comparator: drives the asynchronous output that the sense block watches.
// Assumes the bench sets the wanted level; the output follows after a delay given in ns.
`timescale 1ns/10ps
module cmpis_cmp_model (
    // Control
    input  wire logic       level_i,
    input  wire logic [7:0] delay_i,
    // Comparator output
    output logic            out_o
);
    // The delay is unrelated to the clock, so edges land anywhere in a cycle.
    initial out_o = 1'b0;
    always @(level_i) begin
        out_o <= #(delay_i) level_i;
    end
endmodule : cmpis_cmp_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the comparator sense block, with an inline reference model of the status bits.
// Assumes the register map header and a comparator model beside the design.
`timescale 1ns/10ps
`include "cmpis_map.svh"
module testbench;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o;
    logic        cmp_out_i, cmp_value_o, pin_level, rerr, p0, p1, c0, c1, inv, lvl, ev, lv;
    logic [7:0]  adr_i, dly;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd, r;
    logic [1:0]  src_o, mode, st, en;
    int          err_count, checks, cycles, seed;

    cmpis_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .cmp_out_i(cmp_out_i), .positive_source_select_o(src_o), .cmp_value_o(cmp_value_o), .irq_o(irq_o));
    cmpis_cmp_model i_cmp (.level_i(pin_level), .delay_i(dly), .out_o(cmp_out_i));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_bit

    // Classic single cycle; ack or err and read data are taken at the same edge.
    // A slave that never answers is caught by the cycle ceiling, not here.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        rerr = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    initial begin
        seed = 94029;
        {cyc_i, stb_i, we_i, pin_level} = 4'h0;
        {adr_i, dly, sel_i, dat_i} = 52'h0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `CMPIS_OFF_CONTROL, 32'h0, 4'hF);
        chk_reg(rd, 32'h00000000);
        wb(1'b0, `CMPIS_OFF_STATUS, 32'h0, 4'hF);
        chk_reg(rd, 32'h00000000);
        @(negedge clk_i);
        chk_bit(irq_o, 1'b0);
        wb(1'b1, `CMPIS_OFF_CONTROL, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, `CMPIS_OFF_CONTROL, 32'h0, 4'hF);
        chk_reg(rd, 32'h0000061E);
        chk_reg({30'h0, src_o}, 32'h00000003);
        wb(1'b1, `CMPIS_OFF_CONTROL, rd & 32'h000001FF, 4'h2);
        wb(1'b0, `CMPIS_OFF_CONTROL, 32'h0, 4'hF);
        chk_reg(rd, 32'h0000001E);
        wb(1'b0, 8'h10, 32'h0, 4'hF);
        chk_bit(rerr, 1'b1);
        // Every mode, polarity and level select, with and without a pin change.
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            p0 = r[0];
            en = r[2:1];
            dly = {5'h0, r[6:4]};
            mode = i[1:0];
            inv = i[2];
            lvl = i[3];
            p1 = i[4] ? ~p0 : p0;
            pin_level <= p0;
            repeat (10) @(posedge clk_i);
            wb(1'b1, `CMPIS_OFF_CONTROL, {27'h0, lvl, mode, inv, 1'b0}, 4'hF);
            wb(1'b1, `CMPIS_OFF_INT_ENABLE, {30'h0, en}, 4'hF);
            wb(1'b1, `CMPIS_OFF_INT_CLEAR, 32'h3, 4'hF);
            pin_level <= p1;
            repeat (10) @(posedge clk_i);
            c0 = p0 ^ inv;
            c1 = p1 ^ inv;
            ev = (mode == 2'h0) ? (lvl ? (!c0 || !c1) : (c0 || c1)) :
                 (mode == 2'h1) ? (c0 && !c1) : (mode == 2'h2) ? (!c0 && c1) : (c0 != c1);
            st = {c0 != c1, ev};
            wb(1'b0, `CMPIS_OFF_STATUS, 32'h0, 4'hF);
            chk_reg(rd, {30'h0, st});
            @(negedge clk_i);
            chk_bit(irq_o, |(st & en));
            wb(1'b0, `CMPIS_OFF_OUTPUT, 32'h0, 4'hF);
            chk_reg(rd, {30'h0, c1, 1'b0});
            @(negedge clk_i);
            chk_bit(cmp_value_o, c1);
            wb(1'b1, `CMPIS_OFF_INT_CLEAR, 32'h3, 4'hF);
            wb(1'b0, `CMPIS_OFF_STATUS, 32'h0, 4'hF);
            lv = (mode == 2'h0) && (lvl ? !c1 : c1);
            chk_reg(rd, {31'h0, lv});
            @(negedge clk_i);
            chk_bit(irq_o, lv & en[0]);
        end
        // A reset in mid-run must bring control and enable back to their reset values.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `CMPIS_OFF_CONTROL, 32'h0, 4'hF);
        chk_reg(rd, `CMPIS_CONTROL_RESET);
        wb(1'b0, `CMPIS_OFF_INT_ENABLE, 32'h0, 4'hF);
        chk_reg(rd, 32'h00000000);
        @(negedge clk_i);
        chk_bit(irq_o, 1'b0);
        test_done();
    end
endmodule : testbench
